// ---- bench/gpb_pin_model.sv ----
// Board side of the pads: outside drivers, pull-ups and lines left floating.
`timescale 1ns/1ns
module gpb_pin_model (
    input wire logic mclk,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_pullup,
    input wire logic [gpb_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [gpb_pkg::NUM_PINS-1:0] ext_val,
    input wire logic [1:0] xt_pullup,
    input wire logic [1:0] xt_en,
    input wire logic [1:0] xt_val,
    output logic [gpb_pkg::NUM_PINS-1:0] pin_in,
    output logic [1:0] xt_in
);
    // A pad nobody drives shows a level that flips every cycle, not a kind 0.
    logic float_r = 1'b0;
    always_ff @(posedge mclk) begin
        float_r <= !float_r;
    end
    // The device wins where it drives; else the outside, else pull-up or float.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) |
        (~ext_en & (pin_pullup | {56{float_r}}))));
    assign xt_in = (xt_en & xt_val) | (~xt_en & (xt_pullup | {2{float_r}}));
endmodule // gpb_pin_model

// ---- bench/gpb_port_bank_bench.sv ----
// Self-checking bench of the port bank: register table, pins and reset.
`timescale 1ns/1ns
module gpb_port_bank_bench;
    import gpb_pkg::*;
    typedef struct packed {logic [15:0] ix; logic [15:0] d; logic [3:0] s; logic [15:0] e;} gpb_row_s;
    logic mclk = 1'b0, reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [3:0] pstrb = '0;
    logic [1:0] carrier_src = '0, xt_en = '0, xt_val = '0, xt_in, xt_pullup;
    logic [55:0] ext_en = '0, ext_val = '0, pin_in, pin_out, pin_oe, pin_pullup;
    logic pready, pslverr;
    int errors = 0, compares = 0;
    // Write, read back; port 6 is left out of this package.
    gpb_row_s rows [11] = '{'{16'hf204, 16'h0a05, 4'h3, 16'h0a05},
        '{16'hf20a, 16'h3c5a, 4'h3, 16'h3c5a}, '{16'hf20c, 16'h81c3, 4'h3, 16'h81c3},
        '{16'hf21d, 16'h0077, 4'h1, 16'h0077}, '{16'hf213, 16'hff13, 4'h3, 16'h0013},
        '{16'hf214, 16'h1122, 4'h2, 16'h1100}, '{16'hf202, 16'hffff, 4'h3, 16'hff00},
        '{16'hf262, 16'h0303, 4'h3, 16'h0000}, '{16'hf260, 16'hff00, 4'h3, 16'h00ff},
        '{16'hf231, 16'h005a, 4'h1, 16'h005a}, '{16'hf2f0, 16'hffff, 4'h3, 16'h0003}};
    gpb_port_bank #(.PORT_EQUIP(7'h3f)) i_gpb_port_bank (.mclk(mclk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .xt_in(xt_in),
        .xt_pullup(xt_pullup), .carrier_src(carrier_src));
    gpb_pin_model i_gpb_pin_model (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .xt_pullup(xt_pullup),
        .xt_en(xt_en), .xt_val(xt_val), .pin_in(pin_in), .xt_in(xt_in));
    // -------------------------------------------------------------------
    // Clock, carrier sources, bus and check tasks.
    // -------------------------------------------------------------------
    initial begin
        forever #5 mclk = !mclk;
    end
    always @(posedge mclk) begin
        carrier_src <= carrier_src + 2'd1;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; two idle edges after it let registered pin outputs settle.
    task automatic apb(input logic w, input logic [15:0] ix, input logic [15:0] d,
            input logic [3:0] s);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, ix, 2'b00, 16'h0, d, s};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        {psel, penable} <= 2'b00;
        repeat (2) @(posedge mclk);
    endtask
    task automatic test_done();
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        test_done();
    end
    // -------------------------------------------------------------------
    // Table, then pins, crystal pads, a stray address and a second reset.
    // -------------------------------------------------------------------
    initial begin
        reset <= 1'b1;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (rows[k]) begin
            apb(1'b1, rows[k].ix, rows[k].d, rows[k].s);
            apb(1'b0, rows[k].ix, 16'h0, 4'h0);
            chk($sformatf("reg %h", rows[k].ix), {16'h0, rows[k].e}, q);
        end
        chk("carrier pin 3", {31'h0, carrier_src[0]}, {31'h0, pin_out[3]});
        apb(1'b1, 16'hf222, 16'h0103, 4'h3);
        apb(1'b1, 16'hf221, 16'h0001, 4'h1);
        ext_en[17] <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("pin 16 drive", 32'h3, {30'h0, pin_oe[16], pin_out[16]});
        apb(1'b0, 16'hf220, 16'h0, 4'h0);
        chk("port 2 data", 32'h01fd, q);
        apb(1'b1, 16'hf222, 16'h000b, 4'h1);
        chk("open drain high", 32'h0, {31'h0, pin_oe[16]});
        apb(1'b1, 16'hf221, 16'h0000, 4'h1);
        chk("open drain low", 32'h1, {31'h0, pin_oe[16] & !pin_out[16]});
        apb(1'b1, 16'hf222, 16'h0400, 4'h2);
        chk("pull-up pin 17", 32'h1, {31'h0, pin_pullup[17]});
        apb(1'b1, 16'hf222, 16'h0012, 4'h1);
        apb(1'b0, 16'hf220, 16'h0, 4'h0);
        chk("test readback", 32'h00fe, q);
        xt_en <= 2'b01;
        apb(1'b1, 16'hf2f2, 16'h0505, 4'h3);
        repeat (4) @(posedge mclk);
        apb(1'b0, 16'hf2f0, 16'h0, 4'h0);
        chk("crystal inputs", 32'h2, q);
        chk("crystal pull-ups", 32'h3, {30'h0, xt_pullup});
        apb(1'b0, 16'h1200, 16'h0, 4'h0);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        apb(1'b0, 16'hf203, 16'h0, 4'h0);
        chk("mode port 0 pin 1", 32'h5, q);
        apb(1'b0, 16'hf204, 16'h0, 4'h0);
        chk("mode port 0 pins 2 3", 32'h0, q);
        apb(1'b0, 16'hf200, 16'h0, 4'h0);
        chk("port 0 data", 32'h00ff, q);
        test_done();
    end
endmodule // gpb_port_bank_bench

// ---- bench/gpb_port_bank_properties.sv ----
// Bus and pin checks of the port bank, bound onto its top module.
`timescale 1ns/1ns
module gpb_port_bank_properties
    import gpb_pkg::*;
#(
    parameter logic [6:0] PORT_EQUIP = 7'h7f
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_in,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_pullup,
    input wire logic [gpb_pkg::XT_PINS-1:0] xt_in,
    input wire logic [gpb_pkg::XT_PINS-1:0] xt_pullup,
    input wire logic [1:0] carrier_src
);
    // -------------------------------------------------------------------
    // Helpers and assertions.
    // -------------------------------------------------------------------
    wire rd_acc = psel && penable && !pwrite; // Read access phase.
    // Register of a port the package leaves out; its byte reads are fixed.
    wire absent = paddr[17:10] == BANK_IDX && paddr[9:6] < 4'd7 && !PORT_EQUIP[paddr[8:6]];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    ready_in_access_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
    bank_error_a: assert property (psel && penable |-> pslverr == (paddr[17:10] != BANK_IDX))
        else $error("error response wrong");
    upper_zero_a: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    odd_high_zero_a: assert property (rd_acc && paddr[2] |-> prdata[15:8] == 8'h00)
        else $error("odd index high byte set");
    absent_read_a: assert property (rd_acc && absent |->
        prdata[15:0] == (paddr[5:2] == SUB_DI ? 16'h00ff : 16'h0000)) else $error("absent read");
    // Read data must stand after the access, since the master may sample late.
    hold_read_a: assert property (rd_acc |=> $stable(prdata))
        else $error("read data moved");
    no_drive_absent_a: assert property ((pin_oe & ~PIN_DRIVER) == '0)
        else $error("driver on input-only pin");
    reset_quiet_a: assert property (disable iff (1'b0) reset |->
        pin_oe == '0 && pin_out == '0 && pin_pullup == '0) else $error("pins active in reset");
    pullup_release_a: assert property ($fell(reset) |=> pin_pullup[1])
        else $error("pin 01 pull-up off");
    cover property (psel && penable && pwrite);
    cover property (rd_acc && absent);
    cover property (pslverr);
endmodule // gpb_port_bank_properties

bind gpb_port_bank gpb_port_bank_properties #(.PORT_EQUIP(PORT_EQUIP)) i_props (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .xt_in(xt_in), .xt_pullup(xt_pullup), .carrier_src(carrier_src));

// ---- verilog/gpb_pkg.sv ----
// Shared constants of the general purpose port bank: map, field layout, reset values.
package gpb_pkg;

    // -------------------------------------------------------------------
    // Geometry of the bank.
    // -------------------------------------------------------------------
    localparam int NUM_PORTS = 7;   // Bidirectional ports 0 to 6.
    localparam int PINS = 8;        // Pins per port.
    localparam int NUM_PINS = 56;   // All bidirectional pins.
    localparam int PULSE_PORTS = 4; // Ports 0 to 3 carry pulse registers.
    localparam int XT_PINS = 2;     // Input-only pins on the crystal pads.

    // -------------------------------------------------------------------
    // Register indices; the APB byte address is four times the index.
    // -------------------------------------------------------------------
    localparam logic [15:0] IDX_P0_DATA = 16'hf200, IDX_P0_MODE1 = 16'hf203;
    localparam logic [15:0] IDX_P0_MODE23 = 16'hf204, IDX_P0_MODE45 = 16'hf206;
    localparam logic [15:0] IDX_P0_MODE67 = 16'hf208, IDX_P0_PULSE_CFG = 16'hf20a;
    localparam logic [15:0] IDX_P0_PULSE_SEL = 16'hf20c, IDX_P1_DATA = 16'hf210;
    localparam logic [15:0] IDX_P1_MODE01 = 16'hf212, IDX_P1_MODE23 = 16'hf214;
    localparam logic [15:0] IDX_P1_MODE45 = 16'hf216, IDX_P1_MODE67 = 16'hf218;
    localparam logic [15:0] IDX_P1_PULSE_CFG = 16'hf21a, IDX_P1_PULSE_SEL = 16'hf21c;
    localparam logic [15:0] IDX_P2_DATA = 16'hf220, IDX_P2_MODE01 = 16'hf222;
    localparam logic [15:0] IDX_P2_MODE23 = 16'hf224, IDX_P2_MODE45 = 16'hf226;
    localparam logic [15:0] IDX_P2_MODE67 = 16'hf228, IDX_P2_PULSE_CFG = 16'hf22a;
    localparam logic [15:0] IDX_P2_PULSE_SEL = 16'hf22c, IDX_P3_DATA = 16'hf230;
    localparam logic [15:0] IDX_P3_MODE01 = 16'hf232, IDX_P3_MODE23 = 16'hf234;
    localparam logic [15:0] IDX_P3_PULSE_CFG = 16'hf23a, IDX_P3_PULSE_SEL = 16'hf23c;
    localparam logic [15:0] IDX_P4_DATA = 16'hf240, IDX_P4_MODE01 = 16'hf242;
    localparam logic [15:0] IDX_P4_MODE23 = 16'hf244, IDX_P4_MODE45 = 16'hf246;
    localparam logic [15:0] IDX_P4_MODE67 = 16'hf248, IDX_P5_DATA = 16'hf250;
    localparam logic [15:0] IDX_P5_MODE01 = 16'hf252, IDX_P5_MODE23 = 16'hf254;
    localparam logic [15:0] IDX_P5_MODE45 = 16'hf256, IDX_P5_MODE67 = 16'hf258;
    localparam logic [15:0] IDX_P6_DATA = 16'hf260, IDX_P6_MODE01 = 16'hf262;
    localparam logic [15:0] IDX_P6_MODE23 = 16'hf264, IDX_P6_MODE45 = 16'hf266;
    localparam logic [15:0] IDX_XT_INPUT = 16'hf2f0, IDX_XT_MODE01 = 16'hf2f2;

    // -------------------------------------------------------------------
    // Decode of an index: upper byte selects the bank, then port and slot.
    // -------------------------------------------------------------------
    localparam logic [7:0] BANK_IDX = 8'hf2;  // Index bits 15:8 of every register.
    localparam logic [3:0] PORT_XT = 4'hf;    // Port nibble of the crystal pins.
    localparam logic [3:0] SUB_DI = 4'h0;     // Input level byte.
    localparam logic [3:0] SUB_DO = 4'h1;     // Output latch byte.
    localparam logic [3:0] SUB_MODE0 = 4'h2;  // Mode byte of pin 0.
    localparam logic [3:0] SUB_MODE7 = 4'h9;  // Mode byte of pin 7.
    localparam logic [3:0] SUB_PMD_L = 4'ha;  // Pulse config, low byte.
    localparam logic [3:0] SUB_PMD_H = 4'hb;  // Pulse config, high byte.
    localparam logic [3:0] SUB_PSL_L = 4'hc;  // Pulse select, low byte.
    localparam logic [3:0] SUB_PSL_H = 4'hd;  // Pulse select, high byte.
    localparam logic [3:0] XT_SUB_MODE0 = 4'h2; // Mode byte of crystal pin 0.
    localparam logic [3:0] XT_SUB_MODE1 = 4'h3; // Mode byte of crystal pin 1.

    // -------------------------------------------------------------------
    // Mode byte fields and reset values.
    // -------------------------------------------------------------------
    localparam int MODE_IN_EN = 0;     // Input sampling enabled.
    localparam int MODE_OUT_EN = 1;    // Output driver enabled.
    localparam int MODE_PULLUP = 2;    // Internal pull-up on.
    localparam int MODE_OPEN_DRAIN = 3; // N-channel open drain instead of CMOS.
    localparam int MODE_TEST = 4;      // Input byte reads back the driven level.
    localparam logic [7:0] MODE_P01_RESET = 8'h05; // Pin 1 of port 0 after reset.
    localparam logic [7:0] BYTE_RESET = 8'h00;     // Every other byte after reset.
    localparam logic [7:0] DI_UNEQUIPPED = 8'hff;  // Input byte of an absent port.
    // Pins present per port, and pins with an output driver (pin 01 is input only).
    localparam logic [55:0] PIN_EXIST = 56'hff_ff_ff_0f_ff_ff_fe;
    localparam logic [55:0] PIN_DRIVER = 56'hff_ff_ff_0f_ff_ff_fc;

endpackage

// ---- verilog/gpb_port_bank.sv ----
// General purpose port bank: pin data, mode and pulse registers on an APB slave.
`timescale 1ns/1ns

// How it works
// RQ1: Every bidirectional pin selects input or output.
// RQ2: One access samples or drives eight pins.
// RQ3: Crystal pins are input only, no driver.
// RQ4: Each pin has its own pull-up switch.
// RQ5: Each pin chooses CMOS or open drain.
// RQ6: Pulse registers put a carrier on pins.
// RQ7: Test mode reads back driven output levels.
// RQ8: Writes to absent ports change nothing.
// RQ9: Absent port input byte reads all ones.
// RQ10: Other registers of absent ports read zero.
// RQ11: Data register: inputs low, latch high byte.
// RQ12: One mode byte per pin, paired words.
// RQ13: Pulse registers have separate low, high bytes.
// RQ14: Port 0 pin 1 mode resets 0x05.
// RQ15: Crystal pin levels in bits 0 and 1.
// RQ16: Enabled output drives latch; input reads pin.
// RQ17: Latch stays writable with output disabled.
// RQ18: Reserved addresses ignore writes, read zero.
// RQ19: Word access only at even index.
module gpb_port_bank #(
    parameter logic [6:0] PORT_EQUIP = 7'h7f // Ports equipped in this package.
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [gpb_pkg::NUM_PINS-1:0] pin_in,
    output logic [gpb_pkg::NUM_PINS-1:0] pin_out,
    output logic [gpb_pkg::NUM_PINS-1:0] pin_oe,
    output logic [gpb_pkg::NUM_PINS-1:0] pin_pullup,
    input wire logic [gpb_pkg::XT_PINS-1:0] xt_in,
    output logic [gpb_pkg::XT_PINS-1:0] xt_pullup,
    input wire logic [1:0] carrier_src
);
    import gpb_pkg::*;

    // -------------------------------------------------------------------
    // Storage.
    // -------------------------------------------------------------------
    logic [7:0] latch_r [NUM_PORTS];          // Output latch byte per port.
    logic [7:0] mode_r [NUM_PORTS][PINS];     // Mode byte per pin.
    logic [15:0] pmd_r [PULSE_PORTS];         // Low: pulse enable, high: inversion.
    logic [15:0] psl_r [PULSE_PORTS];         // Low: carrier choice per pin.
    logic [7:0] xtmode_r [XT_PINS];           // Mode bytes of the crystal pins.
    logic [NUM_PINS-1:0] pin_meta_r;          // First synchroniser stage.
    logic [NUM_PINS-1:0] pin_sync_r;          // Second synchroniser stage.
    logic [XT_PINS-1:0] xt_meta_r;            // First stage, crystal pins.
    logic [XT_PINS-1:0] xt_sync_r;            // Second stage, crystal pins.
    logic [NUM_PINS-1:0] pin_out_nxt;         // Next driven level.
    logic [NUM_PINS-1:0] pin_oe_nxt;          // Next driver enable.
    logic [NUM_PINS-1:0] pin_pullup_nxt;      // Next pull-up enable.
    logic [7:0] din_byte [NUM_PORTS];         // Input level byte per port.
    logic [1:0] wen;                          // Write strobe per byte lane.
    logic [7:0] widx [2];                     // Index low byte per lane.
    logic [7:0] wdat [2];                     // Write data per lane.
    logic bus_hit;                            // Address falls in the bank.
    logic [31:0] prdata_nxt;                  // Read data for the coming access.

    // -------------------------------------------------------------------
    // Decode helpers.
    // -------------------------------------------------------------------

    // True when the index names a storage byte that exists and is equipped.
    function automatic logic writable(input logic [7:0] idx);
        logic [3:0] port;
        logic [3:0] sub;
        logic [5:0] pin_n;
        port = idx[7:4];
        sub = idx[3:0];
        pin_n = {port[2:0], 3'(sub - SUB_MODE0)};
        writable = 1'b0;
        if (port == PORT_XT) begin
            writable = (sub == XT_SUB_MODE0) || (sub == XT_SUB_MODE1);
        end else if (port < 4'(NUM_PORTS) && PORT_EQUIP[port[2:0]]) begin // RQ8
            if (sub == SUB_DO) begin
                writable = 1'b1;
            end else if (sub >= SUB_MODE0 && sub <= SUB_MODE7) begin
                writable = PIN_EXIST[pin_n]; // RQ18
            end else if (sub >= SUB_PMD_L && sub <= SUB_PSL_H) begin
                writable = port < 4'(PULSE_PORTS); // RQ18
            end
        end
    endfunction

    // Read value of one byte of the map.
    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        logic [3:0] port;
        logic [3:0] sub;
        logic [2:0] p;
        logic [1:0] q;
        port = idx[7:4];
        sub = idx[3:0];
        p = port[2:0];
        q = port[1:0];
        rd_byte = 8'h00; // RQ18
        if (port == PORT_XT) begin
            if (sub == SUB_DI) begin
                rd_byte = {6'h00, xt_read()}; // RQ15
            end else if (writable(idx)) begin
                rd_byte = xtmode_r[sub[0]];
            end
        end else if (port < 4'(NUM_PORTS)) begin
            if (!PORT_EQUIP[p]) begin
                rd_byte = (sub == SUB_DI) ? DI_UNEQUIPPED : 8'h00; // RQ9 RQ10
            end else if (sub == SUB_DI) begin
                rd_byte = din_byte[p]; // RQ11
            end else if (writable(idx)) begin
                case (sub)
                    SUB_DO: begin
                        rd_byte = latch_r[p]; // RQ11 RQ17
                    end
                    SUB_PMD_L: begin
                        rd_byte = pmd_r[q][7:0];
                    end
                    SUB_PMD_H: begin
                        rd_byte = pmd_r[q][15:8];
                    end
                    SUB_PSL_L: begin
                        rd_byte = psl_r[q][7:0];
                    end
                    SUB_PSL_H: begin
                        rd_byte = psl_r[q][15:8];
                    end
                    default: begin
                        rd_byte = mode_r[p][3'(sub - SUB_MODE0)]; // RQ12
                    end
                endcase
            end
        end
    endfunction

    // Crystal pin levels; a pin with input disabled reads high.
    function automatic logic [1:0] xt_read();
        xt_read[0] = xtmode_r[0][MODE_IN_EN] ? xt_sync_r[0] : 1'b1;
        xt_read[1] = xtmode_r[1][MODE_IN_EN] ? xt_sync_r[1] : 1'b1;
    endfunction

    // -------------------------------------------------------------------
    // Pin input synchronisers.
    // -------------------------------------------------------------------

    // Pads change with no regard for mclk, so two stages come first.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_meta_r <= '1;
            pin_sync_r <= '1;
            xt_meta_r <= '1;
            xt_sync_r <= '1;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
            xt_meta_r <= xt_in; // RQ3
            xt_sync_r <= xt_meta_r;
        end
    end

    // Input level bytes: all eight pins of a port sampled together.
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i < PINS; i++) begin
                if (!PIN_EXIST[p*PINS+i]) begin
                    din_byte[p][i] = 1'b1;
                end else if (mode_r[p][i][MODE_TEST]) begin
                    // Reads the level the block drives, not the pad.
                    din_byte[p][i] = pin_out[p*PINS+i]; // RQ7
                end else if (mode_r[p][i][MODE_IN_EN]) begin
                    din_byte[p][i] = pin_sync_r[p*PINS+i]; // RQ2 RQ16
                end else begin
                    din_byte[p][i] = 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // APB slave.
    // -------------------------------------------------------------------

    // Every access finishes in its first access cycle.
    assign pready = 1'b1;
    assign bus_hit = (paddr[17:10] == BANK_IDX);
    // Only addresses outside the bank are errors; reserved slots read zero.
    assign pslverr = psel & penable & ~bus_hit;

    // Byte lanes: lane 1 reaches the odd partner only from an even index.
    always_comb begin
        widx[0] = paddr[9:2];
        widx[1] = {paddr[9:3], 1'b1};
        wdat[0] = pwdata[7:0];
        wdat[1] = pwdata[15:8];
        wen[0] = psel & penable & pwrite & bus_hit & pstrb[0] & writable(widx[0]); // RQ8
        wen[1] = psel & penable & pwrite & bus_hit & pstrb[1] & ~paddr[2]
                 & writable(widx[1]); // RQ19
    end

    // Read data is prepared in the setup cycle so it comes from a flip-flop.
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (bus_hit) begin
            prdata_nxt[7:0] = rd_byte(widx[0]);
            if (!paddr[2]) begin
                prdata_nxt[15:8] = rd_byte(widx[1]); // RQ19
            end
        end
    end

    // Capture read data at the setup edge; hold it otherwise.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Register writes, one process per register kind.
    // -------------------------------------------------------------------

    // Output latches; writable whatever the pin direction.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                latch_r[p] <= BYTE_RESET; // RQ14
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (wen[k] && widx[k][7:4] != PORT_XT && widx[k][3:0] == SUB_DO) begin
                    latch_r[widx[k][6:4]] <= wdat[k]; // RQ2 RQ17
                end
            end
        end
    end

    // Pin mode bytes.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                for (int i = 0; i < PINS; i++) begin
                    mode_r[p][i] <= BYTE_RESET;
                end
            end
            mode_r[0][1] <= MODE_P01_RESET; // RQ14
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (wen[k] && widx[k][7:4] != PORT_XT && widx[k][3:0] >= SUB_MODE0
                    && widx[k][3:0] <= SUB_MODE7) begin
                    mode_r[widx[k][6:4]][3'(widx[k][3:0] - SUB_MODE0)] <= wdat[k]; // RQ12
                end
            end
        end
    end

    // Pulse config and select, each byte written on its own.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int q = 0; q < PULSE_PORTS; q++) begin
                pmd_r[q] <= {BYTE_RESET, BYTE_RESET};
                psl_r[q] <= {BYTE_RESET, BYTE_RESET};
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (wen[k] && widx[k][7:4] != PORT_XT) begin
                    case (widx[k][3:0])
                        SUB_PMD_L: begin
                            pmd_r[widx[k][5:4]][7:0] <= wdat[k]; // RQ13
                        end
                        SUB_PMD_H: begin
                            pmd_r[widx[k][5:4]][15:8] <= wdat[k]; // RQ13
                        end
                        SUB_PSL_L: begin
                            psl_r[widx[k][5:4]][7:0] <= wdat[k]; // RQ13
                        end
                        SUB_PSL_H: begin
                            psl_r[widx[k][5:4]][15:8] <= wdat[k]; // RQ13
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Crystal pin mode bytes.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xtmode_r[0] <= BYTE_RESET;
            xtmode_r[1] <= BYTE_RESET;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (wen[k] && widx[k][7:4] == PORT_XT) begin
                    xtmode_r[widx[k][0]] <= wdat[k]; // RQ15
                end
            end
        end
    end

    // Crystal pads only ever get a pull-up, never a driver.
    assign xt_pullup = {xtmode_r[1][MODE_PULLUP], xtmode_r[0][MODE_PULLUP]}; // RQ3

    // -------------------------------------------------------------------
    // Pin drivers.
    // -------------------------------------------------------------------

    // Level, enable and pull-up per pin. The carrier is used as it comes,
    // so its edges reach the pad one mclk later than the timer makes them.
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i < PINS; i++) begin
                pin_out_nxt[p*PINS+i] = latch_r[p][i]; // RQ16
                if (p < PULSE_PORTS && pmd_r[p % PULSE_PORTS][i]) begin
                    pin_out_nxt[p*PINS+i] = carrier_src[psl_r[p % PULSE_PORTS][i]]
                        ^ pmd_r[p % PULSE_PORTS][PINS+i]; // RQ6
                end
                // Open drain only sinks, so the driver is off for a high level.
                pin_oe_nxt[p*PINS+i] = PIN_DRIVER[p*PINS+i] & mode_r[p][i][MODE_OUT_EN]
                    & (~mode_r[p][i][MODE_OPEN_DRAIN] | ~pin_out_nxt[p*PINS+i]); // RQ1 RQ5
                pin_pullup_nxt[p*PINS+i] = PIN_EXIST[p*PINS+i]
                    & mode_r[p][i][MODE_PULLUP]; // RQ4
            end
        end
    end

    // Pad controls come from flip-flops to keep glitches off the pins.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
        end else begin
            pin_out <= pin_out_nxt;
            pin_oe <= pin_oe_nxt;
            pin_pullup <= pin_pullup_nxt;
        end
    end

endmodule // gpb_port_bank
